// ==== bench/diag_and_socket_dma_config_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dsdc_consts.svh"
module diag_and_socket_dma_config_tb;
  localparam logic [15:0] VID = 16'h1234; // Arbitrary value
  localparam logic [15:0] DID = 16'h5678; // Arbitrary value
  // Shortened discard counts keep the run brief
  localparam int LNG = 64;
  localparam int SHT = 16;
  int error_cnt = 0, tests_run = 0, cyc = 0, n, m;
  logic mclk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, io_addr = 32'h0, prdata;
  logic target_wait = 1'b0, io_addr_valid = 1'b0, evt = 1'b0;
  logic card_dt_start = 1'b0, card_dt_claim = 1'b0, host_dt_start = 1'b0, host_dt_claim = 1'b0;
  logic [2:0] lvl = 3'h0;
  logic pready, pslverr, irq, status_change_legacy, retry_now, delayed_txn_en, card_dt_discard;
  logic host_dt_discard, card_spkr, card_iois16, card_inpack, card_dma_request, dma_window_hit;
  logic dma_width_16, card_status_change;
  logic [4:0] evt_v;
  assign evt_v = {status_change_legacy, irq, host_dt_discard, card_dt_discard, retry_now};
  always #2 mclk = ~mclk;
  dsdc_top #(.VENDOR_ID(VID), .DEVICE_ID(DID), .DISCARD_LONG_CYC(LNG),
    .DISCARD_SHORT_CYC(SHT)) i_dut (.mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .irq, .card_status_change, .status_change_legacy,
    .target_wait, .retry_now, .delayed_txn_en, .card_dt_start, .card_dt_claim,
    .host_dt_start, .host_dt_claim, .card_dt_discard, .host_dt_discard, .card_spkr,
    .card_iois16, .card_inpack, .card_dma_request, .io_addr_valid, .io_addr, .dma_window_hit,
    .dma_width_16);
  dsdc_card_model i_card (.mclk(mclk), .lvl(lvl), .evt(evt), .spkr(card_spkr),
    .iois16(card_iois16), .inpack(card_inpack), .status_change(card_status_change));
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 10000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, i, d, r, e);
  endtask : wr
  task automatic rd(input logic [9:0] i, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, i, 32'h0, r, e);
    chk(r, x);
  endtask : rd
  task automatic wt(input int c);
    repeat (c) @(posedge mclk);
  endtask : wt
  // Edges until the chosen event shows, 150 meaning never
  task automatic cnt(input int k, output int c);
    c = 0;
    while (evt_v[k] !== 1'b1 && c < 150) begin
      @(posedge mclk);
      c++;
    end
  endtask : cnt
  task automatic rng(input int c, input int lo);
    chk(32'(c >= lo && c <= lo + 3), 32'h1);
  endtask : rng
  task automatic sc(input int k, output int c);
    evt <= 1'b1;
    @(posedge mclk);
    evt <= 1'b0;
    cnt(k, c);
  endtask : sc
  task automatic go(input logic card, input logic claim);
    card_dt_start <= card & ~claim;
    host_dt_start <= ~card;
    card_dt_claim <= claim;
    @(posedge mclk);
    {card_dt_start, host_dt_start, card_dt_claim} <= 3'h0;
  endtask : go
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rd(`DSDC_IDX_DIAG, 32'h61);
    rd(`DSDC_IDX_ID, {DID, VID});
    wr(`DSDC_IDX_DIAG, 32'hff);
    rd(`DSDC_IDX_DIAG, 32'hff);
    rd(`DSDC_IDX_ID, 32'hffffffff);
    wr(`DSDC_IDX_DIAG, 32'h21);
    rd(`DSDC_IDX_DIAG, 32'h21);
    rd(`DSDC_IDX_ID, {DID, VID});
    wr(`DSDC_IDX_DIAG, 32'h61);
    apb(1'b0, 10'h0aa, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    $display("register test done");
  endtask : t_regs
  task automatic t_pin();
    rd(`DSDC_IDX_REQSEL, 32'h0);
    for (int s = 0; s < 4; s++) begin
      wr(`DSDC_IDX_REQSEL, 32'hfffffffc | 32'(s));
      rd(`DSDC_IDX_REQSEL, 32'(s));
      for (int p = 0; p < 3; p++) begin
        lvl <= 3'h7 ^ (3'h1 << p);
        wt(3);
        chk(32'(card_dma_request), 32'(s != 0 && p != s - 1));
      end
    end
    $display("request pin test done");
  endtask : t_pin
  task automatic hit(input logic [31:0] a, input logic x);
    io_addr <= a;
    io_addr_valid <= 1'b1;
    wt(2);
    chk(32'(dma_window_hit), 32'(x));
    io_addr_valid <= 1'b0;
    wt(1);
  endtask : hit
  task automatic t_win();
    rd(`DSDC_IDX_WIN, 32'h0);
    wr(`DSDC_IDX_WIN, 32'hffffffff);
    rd(`DSDC_IDX_WIN, 32'h0000fff7);
    wr(`DSDC_IDX_WIN, 32'h00001231);
    hit(32'h1230, 1'b1);
    hit(32'h123f, 1'b1);
    hit(32'h1240, 1'b0);
    hit(32'h122f, 1'b0);
    hit(32'h10001230, 1'b0);
    wr(`DSDC_IDX_WIN, 32'h00001230);
    hit(32'h1230, 1'b0);
    for (int w = 0; w < 4; w++) begin
      wr(`DSDC_IDX_WIN, 32'(w << 1));
      rd(`DSDC_IDX_WIN, 32'(w << 1));
      chk(32'(dma_width_16), 32'(w == 1));
    end
    $display("window test done");
  endtask : t_win
  task automatic t_irq();
    wr(`DSDC_IDX_IRQ_MASK, 32'h1);
    sc(3, m);
    rd(`DSDC_IDX_IRQ_STAT, 32'h1);
    wr(`DSDC_IDX_IRQ_STAT, 32'h1);
    wt(3);
    chk(32'(irq), 32'h0);
    wr(`DSDC_IDX_DIAG, 32'h60);
    sc(3, n);
    chk(32'(n - m), 32'h1);
    wr(`DSDC_IDX_IRQ_STAT, 32'h1);
    wr(`DSDC_IDX_DIAG, 32'h61);
    wr(`DSDC_IDX_ROUTE, 32'h10);
    // Not routed to the host: legacy pulse instead
    sc(4, n);
    chk(32'(n < 5), 32'h1);
    rd(`DSDC_IDX_IRQ_STAT, 32'h0);
    wr(`DSDC_IDX_DIAG, 32'h41);
    wr(`DSDC_IDX_ROUTE, 32'h11);
    sc(3, n);
    chk(32'(n < 5), 32'h1);
    wr(`DSDC_IDX_IRQ_STAT, 32'h1);
    wr(`DSDC_IDX_IRQ_MASK, 32'h0);
    wr(`DSDC_IDX_ROUTE, 32'h0);
    wr(`DSDC_IDX_DIAG, 32'h61);
    sc(3, n);
    chk(32'(n), 32'd150);
    rd(`DSDC_IDX_IRQ_STAT, 32'h1);
    wr(`DSDC_IDX_IRQ_STAT, 32'h1);
    $display("interrupt test done");
  endtask : t_irq
  task automatic t_tmr();
    chk(32'(delayed_txn_en), 32'h1);
    target_wait <= 1'b1;
    cnt(0, n);
    target_wait <= 1'b0;
    rng(n, 16);
    wr(`DSDC_IDX_DIAG, 32'h69);
    target_wait <= 1'b1;
    cnt(0, n);
    target_wait <= 1'b0;
    rng(n, 64);
    wr(`DSDC_IDX_DIAG, 32'h63);
    go(1'b1, 1'b0);
    cnt(1, n);
    rng(n, LNG);
    go(1'b0, 1'b0);
    cnt(2, n);
    rng(n, SHT);
    wr(`DSDC_IDX_DIAG, 32'h65);
    go(1'b1, 1'b0);
    cnt(1, n);
    rng(n, SHT);
    go(1'b1, 1'b0);
    wt(4);
    go(1'b1, 1'b1);
    cnt(1, n);
    chk(32'(n), 32'd150);
    wr(`DSDC_IDX_DIAG, 32'h71);
    wt(2);
    chk(32'(delayed_txn_en), 32'h0);
    go(1'b1, 1'b0);
    cnt(1, n);
    chk(32'(n), 32'd150);
    $display("timer test done");
  endtask : t_tmr
  initial begin
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    t_regs();
    t_pin();
    t_win();
    t_irq();
    t_tmr();
    test_done();
  end
endmodule : diag_and_socket_dma_config_tb
`default_nettype wire

// ==== bench/dsdc_card_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dsdc_card_model (
  input wire logic mclk,
  input wire logic [2:0] lvl,
  input wire logic evt,
  output logic spkr,
  output logic iois16,
  output logic inpack,
  output logic status_change
);
  // Socket pins move only just after an edge
  always @(posedge mclk) begin
    {inpack, iois16, spkr} <= lvl;
    status_change <= evt;
  end
endmodule : dsdc_card_model
`default_nettype wire

// ==== shared/dsdc_consts.svh ====
`ifndef DSDC_CONSTS_SVH
`define DSDC_CONSTS_SVH
// Register indices; byte address is four times the index
`define DSDC_IDX_ID 10'h000
`define DSDC_IDX_DIAG 10'h093
`define DSDC_IDX_REQSEL 10'h094
`define DSDC_IDX_WIN 10'h098
`define DSDC_IDX_IRQ_STAT 10'h09c
`define DSDC_IDX_IRQ_MASK 10'h09d
`define DSDC_IDX_ROUTE 10'h09e
// Reset values
`define DSDC_DIAG_RST 8'h61
`define DSDC_REQSEL_RST 2'h0
`define DSDC_WIN_BASE_RST 12'h000
`define DSDC_WIN_WIDTH_RST 2'h0
`define DSDC_WIN_EN_RST 1'b0
`define DSDC_ROUTE_RST 5'h00
// Diagnostic field positions
`define DSDC_B_ID_MASK 7
`define DSDC_B_SPARE 6
`define DSDC_B_ROUTE_SEL 5
`define DSDC_B_DT_OFF 4
`define DSDC_B_RETRY_LONG 3
`define DSDC_B_CARD_DISC 2
`define DSDC_B_HOST_DISC 1
`define DSDC_B_ASYNC 0
// Interrupt status bit positions
`define DSDC_S_STCHG 0
`define DSDC_S_RETRY 1
`define DSDC_S_CARD_DISC 2
`define DSDC_S_HOST_DISC 3
// Timing counts in clocks
`define DSDC_RETRY_SHORT 7'd16
`define DSDC_RETRY_LONG 7'd64
`define DSDC_DISCARD_SHORT 32'd1024
`define DSDC_DISCARD_LONG 32'd32768
`endif

// ==== shared/dsdc_pkg.sv ====
`default_nettype none
package dsdc_pkg;
  typedef enum logic [1:0] {pin_off, pin_spkr, pin_iois16, pin_inpack} dsdc_pin_t;
  typedef enum logic [1:0] {width_8, width_16, width_rsv2, width_rsv3} dsdc_width_t;
  typedef enum logic [1:0] {retry_idle, retry_wait, retry_done} dsdc_retry_st_t;
endpackage : dsdc_pkg
`default_nettype wire

// ==== shared/dsdc_tmr_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface dsdc_tmr_if;
  logic start;
  logic cancel;
  logic short_sel;
  logic expire;
  modport ctrl (output start, output cancel, output short_sel, input expire);
  modport tmr (input start, input cancel, input short_sel, output expire);
endinterface : dsdc_tmr_if
`default_nettype wire

// ==== verilog/dsdc_discard_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dsdc_consts.svh"
module dsdc_discard_timer #(
  parameter int unsigned LONG_CYC = `DSDC_DISCARD_LONG,
  parameter int unsigned SHORT_CYC = `DSDC_DISCARD_SHORT
) (
  input wire logic mclk,
  input wire logic srst,
  dsdc_tmr_if.tmr tif
);
  logic [15:0] cnt_r;
  logic armed_r;
  logic expire_r;
  wire [15:0] limit = tif.short_sel ? 16'(SHORT_CYC - 1) : 16'(LONG_CYC - 1);
  wire hit = armed_r && (cnt_r == limit);

  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_r <= 16'h0000;
      armed_r <= 1'b0;
      expire_r <= 1'b0;
    end else begin
      expire_r <= hit && !tif.cancel && !tif.start;
      if (tif.start) begin
        armed_r <= 1'b1;
        cnt_r <= 16'h0000;
      end else if (tif.cancel || hit) begin
        armed_r <= 1'b0;
      end else if (armed_r) begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end

  assign tif.expire = expire_r;

  tmr_expire_cause_a: assert property (@(posedge mclk) disable iff (srst)
    tif.expire |-> $past(armed_r) && $past(cnt_r) == $past(limit))
    else $error("discard expiry without a full count");
endmodule : dsdc_discard_timer
`default_nettype wire

// ==== verilog/dsdc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dsdc_consts.svh"
module dsdc_top #(
  parameter logic [15:0] VENDOR_ID = 16'h1234, // Arbitrary value
  parameter logic [15:0] DEVICE_ID = 16'h5678, // Arbitrary value
  parameter int unsigned DISCARD_LONG_CYC = `DSDC_DISCARD_LONG,
  parameter int unsigned DISCARD_SHORT_CYC = `DSDC_DISCARD_SHORT
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic irq,
  input wire logic card_status_change,
  output logic status_change_legacy,
  input wire logic target_wait,
  output logic retry_now,
  output logic delayed_txn_en,
  input wire logic card_dt_start,
  input wire logic card_dt_claim,
  input wire logic host_dt_start,
  input wire logic host_dt_claim,
  output logic card_dt_discard,
  output logic host_dt_discard,
  input wire logic card_spkr,
  input wire logic card_iois16,
  input wire logic card_inpack,
  output logic card_dma_request,
  input wire logic io_addr_valid,
  input wire logic [31:0] io_addr,
  output logic dma_window_hit,
  output logic dma_width_16
);
  logic [7:0] diag_r;
  dsdc_pkg::dsdc_pin_t dma_request_pin_select_r;
  logic [11:0] dma_window_base_r;
  dsdc_pkg::dsdc_width_t dma_transfer_width_r;
  logic dma_window_decode_enable_r;
  logic [3:0] irq_stat_r;
  logic [3:0] irq_stat_nxt;
  logic [3:0] irq_mask_r;
  logic [4:0] route_r;
  logic [31:0] prdata_nxt;
  logic stchg_dly_r;
  dsdc_pkg::dsdc_retry_st_t retry_st_r;
  logic [6:0] wait_cnt_r;

  // APB decode
  wire [9:0] idx = paddr[11:2];
  wire setup = psel && !penable;
  wire wr_go = psel && penable && pready && pwrite;
  wire hit_id = (idx == `DSDC_IDX_ID);
  wire hit_diag = (idx == `DSDC_IDX_DIAG);
  wire hit_reqsel = (idx == `DSDC_IDX_REQSEL);
  wire hit_win = (idx == `DSDC_IDX_WIN);
  wire hit_stat = (idx == `DSDC_IDX_IRQ_STAT);
  wire hit_mask = (idx == `DSDC_IDX_IRQ_MASK);
  wire hit_route = (idx == `DSDC_IDX_ROUTE);
  wire mapped = hit_id | hit_diag | hit_reqsel | hit_win | hit_stat | hit_mask | hit_route;
  wire id_mask = diag_r[`DSDC_B_ID_MASK];
  wire dt_off = diag_r[`DSDC_B_DT_OFF];

  wire [31:0] id_word = id_mask ? 32'hffffffff : {DEVICE_ID, VENDOR_ID};
  wire [31:0] reqsel_word = {30'h00000000, dma_request_pin_select_r};
  // extended bit and upper half read zero
  wire [31:0] win_word = {16'h0000, dma_window_base_r, 1'b0, dma_transfer_width_r,
                          dma_window_decode_enable_r};

  always_comb begin
    prdata_nxt = 32'h00000000;
    if (hit_id) prdata_nxt = id_word;
    else if (hit_diag) prdata_nxt = {24'h000000, diag_r};
    else if (hit_reqsel) prdata_nxt = reqsel_word;
    else if (hit_win) prdata_nxt = win_word;
    else if (hit_stat) prdata_nxt = {28'h0000000, irq_stat_r};
    else if (hit_mask) prdata_nxt = {28'h0000000, irq_mask_r};
    else if (hit_route) prdata_nxt = {24'h000000, route_r[4:1], 3'h0, route_r[0]};
  end

  // One wait-free access phase; data latched in setup
  always_ff @(posedge mclk) begin
    if (srst) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite) prdata <= prdata_nxt;
    end
  end

  // whole byte writable, bit 6 kept as plain storage
  always_ff @(posedge mclk) begin
    if (srst) diag_r <= `DSDC_DIAG_RST;
    else if (wr_go && hit_diag) diag_r <= pwdata[7:0];
  end

  // two-bit pin field only; decode off at reset
  always_ff @(posedge mclk) begin
    if (srst) begin
      dma_request_pin_select_r <= dsdc_pkg::dsdc_pin_t'(`DSDC_REQSEL_RST);
      dma_window_base_r <= `DSDC_WIN_BASE_RST;
      dma_transfer_width_r <= dsdc_pkg::dsdc_width_t'(`DSDC_WIN_WIDTH_RST);
      dma_window_decode_enable_r <= `DSDC_WIN_EN_RST;
    end else if (wr_go && hit_reqsel) begin
      dma_request_pin_select_r <= dsdc_pkg::dsdc_pin_t'(pwdata[1:0]);
    end else if (wr_go && hit_win) begin
      dma_window_base_r <= pwdata[15:4];
      dma_transfer_width_r <= dsdc_pkg::dsdc_width_t'(pwdata[2:1]);
      dma_window_decode_enable_r <= pwdata[0];
    end
  end

  // Stand-ins for the legacy 803 bit 4 and 805 bits 7:4
  always_ff @(posedge mclk) begin
    if (srst) route_r <= `DSDC_ROUTE_RST;
    else if (wr_go && hit_route) route_r <= {pwdata[7:4], pwdata[0]};
  end

  always_ff @(posedge mclk) begin
    if (srst) irq_mask_r <= 4'h0;
    else if (wr_go && hit_mask) irq_mask_r <= pwdata[3:0];
  end

  // routing choice between the two legacy fields
  wire route_pci = diag_r[`DSDC_B_ROUTE_SEL] ? (route_r[4:1] == 4'h0) : route_r[0];
  // async path skips the sync stage, costing a glitch-prone input
  wire stchg_evt = diag_r[`DSDC_B_ASYNC] ? card_status_change : stchg_dly_r;

  always_ff @(posedge mclk) begin
    if (srst) begin
      stchg_dly_r <= 1'b0;
      status_change_legacy <= 1'b0;
    end else begin
      stchg_dly_r <= card_status_change;
      status_change_legacy <= stchg_evt && !route_pci;
    end
  end

  // retry limit 16 or 64 clocks
  wire [6:0] retry_lim = diag_r[`DSDC_B_RETRY_LONG] ? `DSDC_RETRY_LONG : `DSDC_RETRY_SHORT;
  wire retry_fire = (retry_st_r == dsdc_pkg::retry_wait) && target_wait
                    && (wait_cnt_r == retry_lim - 7'd1);

  always_ff @(posedge mclk) begin
    if (srst) begin
      retry_st_r <= dsdc_pkg::retry_idle;
      wait_cnt_r <= 7'h00;
      retry_now <= 1'b0;
    end else begin
      retry_now <= retry_fire;
      case (retry_st_r)
        dsdc_pkg::retry_idle: begin
          wait_cnt_r <= 7'h00;
          if (target_wait) retry_st_r <= dsdc_pkg::retry_wait;
        end
        dsdc_pkg::retry_wait: begin
          wait_cnt_r <= wait_cnt_r + 7'h01;
          if (!target_wait) retry_st_r <= dsdc_pkg::retry_idle;
          else if (retry_fire) retry_st_r <= dsdc_pkg::retry_done;
        end
        dsdc_pkg::retry_done: begin
          if (!target_wait) retry_st_r <= dsdc_pkg::retry_idle;
        end
        default: retry_st_r <= dsdc_pkg::retry_idle;
      endcase
    end
  end

  dsdc_tmr_if card_tif ();
  dsdc_tmr_if host_tif ();

  // no delayed transactions, so no discard timers start
  assign card_tif.start = card_dt_start && !dt_off;
  assign card_tif.cancel = card_dt_claim;
  assign card_tif.short_sel = diag_r[`DSDC_B_CARD_DISC];
  assign host_tif.start = host_dt_start && !dt_off;
  assign host_tif.cancel = host_dt_claim;
  assign host_tif.short_sel = diag_r[`DSDC_B_HOST_DISC];

  dsdc_discard_timer #(
    .LONG_CYC(DISCARD_LONG_CYC),
    .SHORT_CYC(DISCARD_SHORT_CYC)
  ) u_card_timer (
    .mclk(mclk),
    .srst(srst),
    .tif(card_tif.tmr)
  );

  dsdc_discard_timer #(
    .LONG_CYC(DISCARD_LONG_CYC),
    .SHORT_CYC(DISCARD_SHORT_CYC)
  ) u_host_timer (
    .mclk(mclk),
    .srst(srst),
    .tif(host_tif.tmr)
  );

  // Sticky status; a new event beats a same-cycle clear
  wire [3:0] evt = {host_tif.expire, card_tif.expire, retry_fire, stchg_evt && route_pci};
  wire [3:0] w1c = (wr_go && hit_stat) ? pwdata[3:0] : 4'h0;
  assign irq_stat_nxt = (irq_stat_r & ~w1c) | evt;

  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_stat_r <= 4'h0;
      irq <= 1'b0;
      delayed_txn_en <= 1'b0;
      card_dt_discard <= 1'b0;
      host_dt_discard <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq <= |(irq_stat_nxt & irq_mask_r);
      delayed_txn_en <= !dt_off;
      card_dt_discard <= card_tif.expire;
      host_dt_discard <= host_tif.expire;
    end
  end

  // request pin mux; off means nothing sampled
  wire req_pin_mux = (dma_request_pin_select_r == dsdc_pkg::pin_spkr) ? card_spkr :
                  (dma_request_pin_select_r == dsdc_pkg::pin_iois16) ? card_iois16 :
                  (dma_request_pin_select_r == dsdc_pkg::pin_inpack) ? card_inpack : 1'b0;
  // 16-byte slot below 64K; upper half must be zero
  wire win_match = (io_addr[31:16] == 16'h0000) && (io_addr[15:4] == dma_window_base_r);
  // reserved widths fall back to 8 bits; 01 is 16-bit
  wire width16 = (dma_transfer_width_r == dsdc_pkg::width_16);

  always_ff @(posedge mclk) begin
    if (srst) begin
      card_dma_request <= 1'b0;
      dma_window_hit <= 1'b0;
      dma_width_16 <= 1'b0;
    end else begin
      card_dma_request <= req_pin_mux;
      dma_window_hit <= io_addr_valid && dma_window_decode_enable_r && win_match;
      dma_width_16 <= width16;
    end
  end

  diag_reset_a: assert property (@(posedge mclk)
    $fell(srst) |-> diag_r == `DSDC_DIAG_RST)
    else $error("diagnostic reset value wrong");

  id_mask_a: assert property (@(posedge mclk) disable iff (srst)
    setup && !pwrite && hit_id |=>
    prdata == ($past(id_mask) ? 32'hffffffff : {DEVICE_ID, VENDOR_ID}))
    else $error("identity read mask wrong");

  reqsel_rsvd_a: assert property (@(posedge mclk) disable iff (srst)
    setup && !pwrite && hit_reqsel |=> prdata[31:2] == 30'h00000000)
    else $error("request select upper bits not zero");

  ext_zero_a: assert property (@(posedge mclk) disable iff (srst)
    setup && !pwrite && hit_win |=> prdata[3] == 1'b0 && prdata[31:16] == 16'h0000)
    else $error("window register fixed bits not zero");

  dma_off_a: assert property (@(posedge mclk) disable iff (srst)
    dma_request_pin_select_r == dsdc_pkg::pin_off |=> !card_dma_request)
    else $error("request raised while pin select off");

  retry_limit_a: assert property (@(posedge mclk) disable iff (srst)
    retry_now |-> $past(wait_cnt_r) == ($past(diag_r[3]) ? 7'd63 : 7'd15))
    else $error("retry fired at wrong count");

  win_off_a: assert property (@(posedge mclk) disable iff (srst)
    !dma_window_decode_enable_r |=> !dma_window_hit)
    else $error("window hit while decode disabled");

  width_cap_a: assert property (@(posedge mclk) disable iff (srst)
    dma_width_16 |-> $past(dma_transfer_width_r) == dsdc_pkg::width_16)
    else $error("wide transfer without 16-bit code");

  dt_off_a: assert property (@(posedge mclk) disable iff (srst)
    diag_r[`DSDC_B_DT_OFF] |=> !delayed_txn_en)
    else $error("delayed transactions left enabled");

  async_stchg_a: assert property (@(posedge mclk) disable iff (srst)
    diag_r[0] && card_status_change && route_pci |=> irq_stat_r[0])
    else $error("async status change not captured at once");
endmodule : dsdc_top
`default_nettype wire
